// File: hdl/servo_brake_pkg.sv
package servo_brake_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS  = 25;
	localparam int unsigned TICK_PERIOD_NS = 1_000_000;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned OVF_UNIT_SHIFT = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam int unsigned ADDR_W         = 8;
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_ROT_SPEED  = 8'h04;
	localparam logic [7:0]  OFS_OVF_LIMIT  = 8'h08;
	localparam logic [7:0]  OFS_SON_WAIT   = 8'h0C;
	localparam logic [7:0]  OFS_BRK_SPEED  = 8'h10;
	localparam logic [7:0]  OFS_BRK_TIME   = 8'h14;
	localparam logic [7:0]  OFS_STATUS     = 8'h18;
	localparam logic [7:0]  OFS_IRQ_STATUS = 8'h1C;
	localparam logic [7:0]  OFS_IRQ_MASK   = 8'h20;

	// Control fields
	localparam int unsigned CTRL_BRAKE_ALLOC = 0;
	localparam int unsigned CTRL_POS_MODE    = 1;
	localparam int unsigned CTRL_WAIT_FLOW   = 2;

	// Status fields
	localparam int unsigned ST_ROTATION   = 0;
	localparam int unsigned ST_OVERFLOW   = 1;
	localparam int unsigned ST_BRAKE      = 2;
	localparam int unsigned ST_EXCITATION = 3;
	localparam int unsigned ST_STATE_LSB  = 4;

	// Interrupt events
	localparam int unsigned IRQ_W          = 4;
	localparam int unsigned IRQ_ROTATION   = 0;
	localparam int unsigned IRQ_OVERFLOW   = 1;
	localparam int unsigned IRQ_BRAKE_SET  = 2;
	localparam int unsigned IRQ_EXCITE_ON  = 3;

	// Reset values
	localparam logic [2:0]  CTRL_RST       = 3'h0;
	localparam logic [15:0] ROT_SPEED_RST  = 16'h0014;
	localparam logic [15:0] OVF_LIMIT_RST  = 16'h0400;
	localparam logic [15:0] SON_WAIT_RST   = 16'h0000;
	localparam logic [15:0] BRK_SPEED_RST  = 16'h0064;
	localparam logic [15:0] BRK_TIME_RST   = 16'h01F4;
	localparam logic [IRQ_W-1:0] IRQ_RST   = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic               brake_alloc;
		logic               pos_mode;
		logic               wait_flow;
		logic [15:0]        rot_speed;
		logic [15:0]        ovf_limit;
		logic signed [15:0] son_wait;
		logic [15:0]        brk_speed;
		logic [15:0]        brk_time;
	} settings_t;

	typedef enum logic [2:0] {
		S_OFF,
		S_ON_WAIT,
		S_RUN,
		S_STOP_WAIT
	} seq_state_t;

endpackage : servo_brake_pkg

// File: hdl/servo_brake_sequencer.sv
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module servo_brake_sequencer
	import servo_brake_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES,
	parameter int unsigned SPEED_W  = 16,
	parameter int unsigned ERR_W    = 32
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [ADDR_W-1:0]         wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	input  wire logic                      servo_on_i,
	input  wire logic signed [SPEED_W-1:0] speed_i,
	input  wire logic signed [ERR_W-1:0]   error_count_i,
	output logic                           rotation_detected_out_o,
	output logic                           error_overflow_alarm_o,
	output logic                           brake_control_out_o,
	output logic                           motor_excitation_o,
	output logic                           irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
	                                            input logic [31:0] new_v,
	                                            input logic [3:0]  sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				res[b*8 +: 8] = new_v[b*8 +: 8];
		return res;
	endfunction : merge_bytes

	function automatic logic [ERR_W-1:0] magnitude(input logic signed [ERR_W-1:0] v);
		return v[ERR_W-1] ? ERR_W'(-v) : ERR_W'(v);
	endfunction : magnitude

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave

	settings_t        cfg;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] events;
	logic [31:0]      next_rdata;
	logic             access;
	logic             wr;
	seq_state_t       state;

	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land on the edge where the master sees ack
	assign wr     = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= access;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg.brake_alloc <= CTRL_RST[CTRL_BRAKE_ALLOC];
			cfg.pos_mode    <= CTRL_RST[CTRL_POS_MODE];
			cfg.wait_flow   <= CTRL_RST[CTRL_WAIT_FLOW];
			cfg.rot_speed   <= ROT_SPEED_RST;
			cfg.ovf_limit   <= OVF_LIMIT_RST;
			cfg.son_wait    <= SON_WAIT_RST;
			cfg.brk_speed   <= BRK_SPEED_RST;
			cfg.brk_time    <= BRK_TIME_RST;
		end
		else if (wr)
		begin
			unique case (wb_adr_i)
				OFS_CTRL:
				begin
					if (wb_sel_i[0])
					begin
						cfg.brake_alloc <= wb_dat_i[CTRL_BRAKE_ALLOC];
						cfg.pos_mode    <= wb_dat_i[CTRL_POS_MODE];
						cfg.wait_flow   <= wb_dat_i[CTRL_WAIT_FLOW];
					end
				end
				OFS_ROT_SPEED:
					cfg.rot_speed <= 16'(merge_bytes({16'h0000, cfg.rot_speed},
					                                 wb_dat_i, wb_sel_i));
				OFS_OVF_LIMIT:
					cfg.ovf_limit <= 16'(merge_bytes({16'h0000, cfg.ovf_limit},
					                                 wb_dat_i, wb_sel_i));
				OFS_SON_WAIT:
					cfg.son_wait <= 16'(merge_bytes({16'h0000, cfg.son_wait},
					                                wb_dat_i, wb_sel_i));
				OFS_BRK_SPEED:
					cfg.brk_speed <= 16'(merge_bytes({16'h0000, cfg.brk_speed},
					                                 wb_dat_i, wb_sel_i));
				OFS_BRK_TIME:
					cfg.brk_time <= 16'(merge_bytes({16'h0000, cfg.brk_time},
					                                wb_dat_i, wb_sel_i));
				default:
				begin
				end
			endcase
		end
	end

	// Set beats clear: an event in the clearing cycle survives
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_status <= IRQ_RST;
		else if (wr && (wb_adr_i == OFS_IRQ_STATUS) && wb_sel_i[0])
			irq_status <= (irq_status & ~wb_dat_i[IRQ_W-1:0]) | events;
		else
			irq_status <= irq_status | events;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_mask <= IRQ_RST;
		else if (wr && (wb_adr_i == OFS_IRQ_MASK) && wb_sel_i[0])
			irq_mask <= wb_dat_i[IRQ_W-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_status & irq_mask);
	end

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		unique case (wb_adr_i)
			OFS_CTRL:
			begin
				next_rdata[CTRL_BRAKE_ALLOC] = cfg.brake_alloc;
				next_rdata[CTRL_POS_MODE]    = cfg.pos_mode;
				next_rdata[CTRL_WAIT_FLOW]   = cfg.wait_flow;
			end
			OFS_ROT_SPEED:  next_rdata[15:0] = cfg.rot_speed;
			OFS_OVF_LIMIT:  next_rdata[15:0] = cfg.ovf_limit;
			OFS_SON_WAIT:   next_rdata[15:0] = cfg.son_wait;
			OFS_BRK_SPEED:  next_rdata[15:0] = cfg.brk_speed;
			OFS_BRK_TIME:   next_rdata[15:0] = cfg.brk_time;
			OFS_STATUS:
			begin
				next_rdata[ST_ROTATION]   = rotation_detected_out_o;
				next_rdata[ST_OVERFLOW]   = error_overflow_alarm_o;
				next_rdata[ST_BRAKE]      = brake_control_out_o;
				next_rdata[ST_EXCITATION] = motor_excitation_o;
				next_rdata[ST_STATE_LSB +: 3] = state;
			end
			OFS_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
			OFS_IRQ_MASK:   next_rdata[IRQ_W-1:0] = irq_mask;
			default:        next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (access && !wb_we_i)
			wb_dat_o <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Speed and error monitors

	logic [ERR_W-1:0] speed_mag;
	logic [ERR_W-1:0] err_mag;
	logic [ERR_W-1:0] ovf_pulses;
	logic             next_rotation;
	logic             next_overflow;
	logic             below_brk_speed;

	assign speed_mag       = magnitude(ERR_W'(speed_i));
	assign err_mag         = magnitude(error_count_i);
	assign ovf_pulses      = ERR_W'({cfg.ovf_limit, {OVF_UNIT_SHIFT{1'b0}}});
	assign next_rotation   = speed_mag > ERR_W'(cfg.rot_speed);
	assign next_overflow   = cfg.pos_mode && (err_mag > ovf_pulses);
	assign below_brk_speed = speed_mag < ERR_W'(cfg.brk_speed);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rotation_detected_out_o <= 1'b0;
		else
			rotation_detected_out_o <= next_rotation;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			error_overflow_alarm_o <= 1'b0;
		else
			error_overflow_alarm_o <= next_overflow;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Delay tick and timers

	logic [$clog2(TICK_DIV)-1:0] div_count;
	logic                        tick;
	logic                        restart;
	logic                        son_expired;
	logic                        brk_expired;
	logic [15:0]                 son_wait_mag;

	// Free-running tick: a delay may run up to one tick short
	always_ff @(posedge clk_i)
	begin
		if (rst_i || (div_count == ($clog2(TICK_DIV))'(TICK_DIV - 1)))
			div_count <= '0;
		else
			div_count <= div_count + 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tick <= 1'b0;
		else
			tick <= (div_count == ($clog2(TICK_DIV))'(TICK_DIV - 1));
	end

	assign son_wait_mag = cfg.son_wait[15] ? 16'(-cfg.son_wait) : 16'(cfg.son_wait);

	tick_delay_timer #(
		.WIDTH     (16)
	) u_son_timer (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.tick_i    (tick),
		.restart_i (restart),
		.limit_i   (son_wait_mag),
		.expired_o (son_expired)
	);

	tick_delay_timer #(
		.WIDTH     (16)
	) u_brk_timer (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.tick_i    (tick),
		.restart_i (restart),
		.limit_i   (cfg.brk_time + 16'h0001),
		.expired_o (brk_expired)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Servo-on / servo-off sequencer

	seq_state_t next_state;
	logic       next_brake;
	logic       next_excite;
	logic       son_d;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			son_d <= 1'b0;
		else
			son_d <= servo_on_i;
	end

	assign restart = servo_on_i ^ son_d;

	always_comb
	begin
		next_state  = state;
		next_brake  = brake_control_out_o;
		next_excite = motor_excitation_o;
		unique case (state)
			S_OFF:
			begin
				next_brake  = 1'b0;
				next_excite = 1'b0;
				if (servo_on_i && !cfg.brake_alloc)
				begin
					next_excite = 1'b1;
					next_state  = S_RUN;
				end
				else if (servo_on_i && (cfg.son_wait == 16'sh0000))
				begin
					next_brake  = 1'b1;
					next_excite = 1'b1;
					next_state  = S_RUN;
				end
				else if (servo_on_i)
				begin
					next_brake  = !cfg.son_wait[15];
					next_excite = cfg.son_wait[15];
					next_state  = S_ON_WAIT;
				end
			end
			S_ON_WAIT:
			begin
				if (!servo_on_i)
				begin
					next_brake  = 1'b0;
					next_excite = 1'b0;
					next_state  = S_OFF;
				end
				else if (son_expired)
				begin
					next_brake  = 1'b1;
					next_excite = 1'b1;
					next_state  = S_RUN;
				end
			end
			S_RUN:
			begin
				if (!servo_on_i)
				begin
					next_excite = 1'b0;
					if (!cfg.brake_alloc || !cfg.wait_flow)
					begin
						next_brake = 1'b0;
						next_state = S_OFF;
					end
					else
						next_state = S_STOP_WAIT;
				end
			end
			S_STOP_WAIT:
			begin
				next_excite = 1'b0;
				// Re-asserted servo-on waits for the brake to drop first
				if (below_brk_speed || brk_expired)
				begin
					next_brake = 1'b0;
					next_state = S_OFF;
				end
			end
			default:
			begin
				next_brake  = 1'b0;
				next_excite = 1'b0;
				next_state  = S_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= S_OFF;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			brake_control_out_o <= 1'b0;
			motor_excitation_o  <= 1'b0;
		end
		else
		begin
			brake_control_out_o <= next_brake;
			motor_excitation_o  <= next_excite;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt events

	always_comb
	begin
		events                = '0;
		events[IRQ_ROTATION]  = next_rotation && !rotation_detected_out_o;
		events[IRQ_OVERFLOW]  = next_overflow && !error_overflow_alarm_o;
		events[IRQ_BRAKE_SET] = !next_brake && brake_control_out_o;
		events[IRQ_EXCITE_ON] = next_excite && !motor_excitation_o;
	end

endmodule : servo_brake_sequencer

// File: hdl/tick_delay_timer.sv
`timescale 1ns/1ps
module tick_delay_timer #(
	parameter int unsigned WIDTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             tick_i,
	input  wire logic             restart_i,
	input  wire logic [WIDTH-1:0] limit_i,
	output logic                  expired_o
);

	logic [WIDTH-1:0] count;

	// Saturates so a long wait never wraps back below the limit
	always_ff @(posedge clk_i)
	begin
		if (rst_i || restart_i)
			count <= '0;
		else if (tick_i && (count != {WIDTH{1'b1}}))
			count <= count + 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || restart_i)
			expired_o <= 1'b0;
		else
			expired_o <= (count >= limit_i);
	end

endmodule : tick_delay_timer

// File: verif/motor_model.sv
`timescale 1ns/1ps
module motor_model #(
	parameter int unsigned SPEED_W = 16,
	parameter int unsigned ERR_W   = 32
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      excitation_i,
	input  wire logic                      brake_i,
	input  wire logic signed [SPEED_W-1:0] cmd_speed_i,
	input  wire logic signed [ERR_W-1:0]   cmd_error_i,
	output logic signed [SPEED_W-1:0]      speed_o,
	output logic signed [ERR_W-1:0]        error_o
);
	// Encoder feedback lags the mechanics by one sample
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			speed_o <= '0;
		// Brake engaged on an unexcited motor locks the shaft
		else if (!brake_i && !excitation_i)
			speed_o <= '0;
		else
			speed_o <= cmd_speed_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			error_o <= '0;
		else
			error_o <= cmd_error_i;
	end
endmodule : motor_model

// File: verif/servo_brake_sequencer_assertions.sv
`timescale 1ns/1ps
module servo_brake_checker
	import servo_brake_pkg::*;
#(
	parameter int unsigned SPEED_W = 16,
	parameter int unsigned ERR_W   = 32
) (
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_we_i,
	input wire logic [ADDR_W-1:0]         wb_adr_i,
	input wire logic [31:0]               wb_dat_o,
	input wire logic                      wb_ack_o,
	input wire logic                      servo_on_i,
	input wire logic signed [SPEED_W-1:0] speed_i,
	input wire logic signed [ERR_W-1:0]   error_count_i,
	input wire logic                      rotation_detected_out_o,
	input wire logic                      error_overflow_alarm_o,
	input wire logic                      brake_control_out_o,
	input wire logic                      motor_excitation_o,
	input wire logic                      irq_o
);
	// Until software opens the mask, nothing may interrupt
	logic mask_seen;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mask_seen <= 1'b0;
		else if (wb_ack_o && wb_we_i && wb_adr_i == OFS_IRQ_MASK)
			mask_seen <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h40
		|-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	rot_idle_a: assert property (speed_i == '0 |=> !rotation_detected_out_o)
		else $error("rotation seen at standstill");
	ovf_idle_a: assert property (error_count_i == '0 |=> !error_overflow_alarm_o)
		else $error("overflow alarm with zero error");
	excite_drop_a: assert property (!servo_on_i |=> !motor_excitation_o)
		else $error("excitation without servo on");
	brake_hold_a: assert property (!servo_on_i |=> !$rose(brake_control_out_o))
		else $error("brake released without servo on");
	irq_masked_a: assert property (!mask_seen |-> !irq_o)
		else $error("interrupt while all masked");
endmodule : servo_brake_checker

bind servo_brake_sequencer servo_brake_checker #(.SPEED_W(SPEED_W), .ERR_W(ERR_W)) seq_check (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.servo_on_i(servo_on_i), .speed_i(speed_i), .error_count_i(error_count_i),
	.rotation_detected_out_o(rotation_detected_out_o),
	.error_overflow_alarm_o(error_overflow_alarm_o),
	.brake_control_out_o(brake_control_out_o),
	.motor_excitation_o(motor_excitation_o), .irq_o(irq_o));

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	import servo_brake_pkg::*;
	localparam int unsigned DIV = 4;
	logic               clk_i;
	logic               rst_i;
	logic               cyc;
	logic               stb;
	logic               we;
	logic               servo_on;
	logic [7:0]         adr;
	logic [31:0]        dat_w;
	logic [31:0]        dat_r;
	logic [31:0]        last_rd;
	logic               ack;
	logic               rot;
	logic               alarm;
	logic               brake;
	logic               excite;
	logic               irq;
	logic signed [15:0] cmd_speed;
	logic signed [15:0] speed;
	logic signed [31:0] cmd_err;
	logic signed [31:0] err;
	wire logic [4:0]    outs;
	int                 miscompares;
	int                 total_checks;
	int                 cycles;
	int                 n;

	assign outs = {irq, excite, brake, alarm, rot};

	servo_brake_sequencer #(.TICK_DIV(DIV)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.servo_on_i(servo_on), .speed_i(speed), .error_count_i(err),
		.rotation_detected_out_o(rot), .error_overflow_alarm_o(alarm),
		.brake_control_out_o(brake), .motor_excitation_o(excite), .irq_o(irq));

	motor_model motor (.clk_i(clk_i), .rst_i(rst_i), .excitation_i(excite), .brake_i(brake),
		.cmd_speed_i(cmd_speed), .cmd_error_i(cmd_err), .speed_o(speed), .error_o(err));

	always #12.5 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc   <= 1'b1;
		stb   <= 1'b1;
		we    <= w;
		adr   <= a;
		dat_w <= d;
		@(posedge clk_i);
		while (ack !== 1'b1)
		begin
			@(posedge clk_i);
			k++;
		end
		last_rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		check("ack_wait", k, 32'h0000_0001);
	endtask : wb

	task wait_bit(input int idx, input logic v);
		n = 0;
		@(posedge clk_i);
		while (outs[idx] !== v)
		begin
			@(posedge clk_i);
			n++;
		end
	endtask : wait_bit

	// Outputs lag the motor model by two registers, so allow four edges
	task drive(input logic [15:0] s, input logic [31:0] e);
		@(posedge clk_i);
		cmd_speed <= s;
		cmd_err   <= e;
		repeat (4) @(posedge clk_i);
	endtask : drive

	task servo(input logic v);
		@(posedge clk_i);
		servo_on <= v;
		repeat (2) @(posedge clk_i);
	endtask : servo

	////////////////////////////////////////////////////////////////////////
	task t_regs;
		wb(1'b0, OFS_ROT_SPEED, 32'h0000_0000);
		check("rot_speed", last_rd, {16'h0000, ROT_SPEED_RST});
		wb(1'b0, OFS_BRK_TIME, 32'h0000_0000);
		check("brk_time", last_rd, {16'h0000, BRK_TIME_RST});
		wb(1'b1, 8'h40, 32'hFFFF_FFFF);
		wb(1'b0, 8'h40, 32'h0000_0000);
		check("unmapped", last_rd, 32'h0000_0000);
	endtask : t_regs

	task t_rotation;
		wb(1'b1, OFS_CTRL, 32'h0000_0000);
		servo(1'b1);
		check("excite", excite, 1'b1);
		check("brake", brake, 1'b0);
		wb(1'b1, OFS_IRQ_STATUS, 32'h0000_000F);
		wb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
		drive(16'h0015, 32'h0000_0000);
		check("rot", rot, 1'b1);
		wait_bit(4, 1'b1);
		check("irq_set", n < 5, 1'b1);
		wb(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
		wait_bit(4, 1'b0);
		check("irq_clr", n < 5, 1'b1);
		drive(16'h0014, 32'h0000_0000);
		check("rot", rot, 1'b0);
		wb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
		drive(16'hFFEB, 32'h0000_0000);
		check("rot", rot, 1'b1);
		check("irq_mask", irq, 1'b0);
		wb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
		wait_bit(4, 1'b1);
		check("irq_open", n < 5, 1'b1);
		drive(16'h0000, 32'h0000_0000);
		servo(1'b0);
		check("brake", brake, 1'b0);
	endtask : t_rotation

	task t_overflow;
		wb(1'b1, OFS_CTRL, 32'h0000_0002);
		wb(1'b1, OFS_OVF_LIMIT, 32'h0000_0002);
		drive(16'h0000, 32'h0000_0201);
		check("ovf", alarm, 1'b1);
		drive(16'h0000, 32'h0000_0200);
		check("ovf", alarm, 1'b0);
		drive(16'h0000, 32'hFFFF_FDFF);
		check("ovf", alarm, 1'b1);
		wb(1'b1, OFS_CTRL, 32'h0000_0000);
		repeat (3) @(posedge clk_i);
		check("ovf", alarm, 1'b0);
		drive(16'h0000, 32'h0000_0000);
	endtask : t_overflow

	task t_son_pos;
		wb(1'b1, OFS_CTRL, 32'h0000_0001);
		wb(1'b1, OFS_SON_WAIT, 32'h0000_0003);
		servo(1'b1);
		check("brake", brake, 1'b1);
		check("excite", excite, 1'b0);
		wait_bit(3, 1'b1);
		check("son_delay", n >= 6 && n <= 16, 1'b1);
		servo(1'b0);
		check("brake", brake, 1'b0);
		check("excite", excite, 1'b0);
	endtask : t_son_pos

	task t_son_neg;
		wb(1'b1, OFS_SON_WAIT, 32'hFFFF_FFFD);
		wb(1'b0, OFS_SON_WAIT, 32'h0000_0000);
		check("son_wait", last_rd, 32'h0000_FFFD);
		servo(1'b1);
		check("excite", excite, 1'b1);
		check("brake", brake, 1'b0);
		wait_bit(2, 1'b1);
		check("son_delay", n >= 6 && n <= 16, 1'b1);
		servo(1'b0);
	endtask : t_son_neg

	task t_wait_speed;
		wb(1'b1, OFS_CTRL, 32'h0000_0005);
		wb(1'b1, OFS_SON_WAIT, 32'h0000_0000);
		servo(1'b1);
		drive(16'h00C8, 32'h0000_0000);
		servo(1'b0);
		check("excite", excite, 1'b0);
		check("brake", brake, 1'b1);
		// Rotating, brake released, unexcited, stop-wait state
		wb(1'b0, OFS_STATUS, 32'h0000_0000);
		check("status", last_rd, 32'h0000_0035);
		drive(16'h0064, 32'h0000_0000);
		check("brake", brake, 1'b1);
		drive(16'h0063, 32'h0000_0000);
		check("brake", brake, 1'b0);
		drive(16'h0000, 32'h0000_0000);
	endtask : t_wait_speed

	task t_wait_time;
		wb(1'b1, OFS_BRK_TIME, 32'h0000_0003);
		wb(1'b1, OFS_IRQ_STATUS, 32'h0000_000F);
		servo(1'b1);
		drive(16'h00C8, 32'h0000_0000);
		servo(1'b0);
		wait_bit(2, 1'b0);
		check("brk_delay", n >= 9 && n <= 20, 1'b1);
		// Rotation rise, brake applied and excitation on were all seen
		wb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
		check("irq_status", last_rd, 32'h0000_000D);
		drive(16'h0000, 32'h0000_0000);
	endtask : t_wait_time

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			final_report;
		end
	end

	initial
	begin
		clk_i     = 1'b0;
		rst_i     = 1'b1;
		cyc       = 1'b0;
		stb       = 1'b0;
		we        = 1'b0;
		adr       = 8'h00;
		dat_w     = 32'h0000_0000;
		servo_on  = 1'b0;
		cmd_speed = 16'h0000;
		cmd_err   = 32'h0000_0000;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_rotation;
		t_overflow;
		t_son_pos;
		t_son_neg;
		t_wait_speed;
		t_wait_time;
		final_report;
	end
endmodule : testbench
